// *** rtl/crs_pkg.sv ***
/*
  Shared constants and types for the CPU register set: register offsets on the
  Wishbone slave, reset values, flag bit positions, vector addresses and the
  encodings of the operation selects. Assumes a single 50 MHz clock domain.
*/
// How it works
// - 8-bit accumulator holds operands and results
// - 16-bit index from two addressable bytes
// - Index forms indexed address; also stores data
// - Reset loads stack pointer with 00FF
// - Reset-stack instruction sets low byte FF only
// - Push decrements, pull increments stack pointer
// - Stack-offset modes add offset to pointer
// - Program counter steps; jumps load a target
// - Reset fetches vector from top bytes, high first
// - Flag bits 6 and 5 always one
// - Overflow flag on signed overflow; signed branches
// - Half-carry from bit 3 on adds
// - Mask blocks interrupts; set after stacking
// - Interrupt stacking skips upper index byte
// - Highest-priority pending interrupt served first
// - Return pulls registers, restoring mask
// - Reset sets mask; clear-mask, a return or a pull into flags clears it
// - Negative flag equals result bit 7
// - Zero flag when result is 00
// - Carry on add carry, subtract borrow, shifts
// - Break runs software interrupt via FFFC
package crs_pkg;

  localparam logic [7:0] CRS_OFS_ACC = 8'h00;
  localparam logic [7:0] CRS_OFS_INDEX = 8'h04;
  localparam logic [7:0] CRS_OFS_SP = 8'h08;
  localparam logic [7:0] CRS_OFS_PC = 8'h0C;
  localparam logic [7:0] CRS_OFS_FLAGS = 8'h10;
  localparam logic [7:0] CRS_OFS_STATUS = 8'h14;

  localparam logic [15:0] CRS_SP_RESET = 16'h00FF;
  localparam logic [7:0] CRS_SP_LOW_RESET = 8'hFF;
  localparam logic [7:0] CRS_FLAGS_RESET = 8'h68;
  localparam logic [7:0] CRS_FLAGS_ONES = 8'h60;
  localparam logic [7:0] CRS_ACC_RESET = 8'h00;
  localparam logic [15:0] CRS_INDEX_RESET = 16'h0000;
  localparam logic [15:0] CRS_PC_RESET = 16'h0000;

  localparam int CRS_BIT_V = 7;
  localparam int CRS_BIT_H = 4;
  localparam int CRS_BIT_I = 3;
  localparam int CRS_BIT_N = 2;
  localparam int CRS_BIT_Z = 1;
  localparam int CRS_BIT_C = 0;

  localparam logic [15:0] CRS_VEC_RESET = 16'hFFFE;
  localparam logic [15:0] CRS_VEC_SWI = 16'hFFFC;
  localparam logic [15:0] CRS_VEC_IRQ_TOP = 16'hFFFA;
  localparam int CRS_IRQ_W = 8;

  localparam logic [2:0] CRS_INT_STACK_LAST = 3'h4;
  localparam logic [2:0] CRS_INT_VEC_HI_STEP = 3'h5;
  localparam logic [2:0] CRS_INT_VEC_LO_STEP = 3'h6;
  localparam logic [2:0] CRS_INT_DONE_STEP = 3'h7;
  localparam logic [2:0] CRS_RTI_DONE_STEP = 3'h5;
  localparam logic [2:0] CRS_RVEC_DONE_STEP = 3'h2;

  typedef enum logic [2:0] {
    CRS_ST_IDLE = 3'b000,
    CRS_ST_RVEC = 3'b001,
    CRS_ST_INTR = 3'b010,
    CRS_ST_RTI = 3'b011
  } crs_state_t;

  typedef enum logic [3:0] {
    CRS_ALU_ADD = 4'b0000,
    CRS_ALU_ADC = 4'b0001,
    CRS_ALU_SUB = 4'b0010,
    CRS_ALU_SBC = 4'b0011,
    CRS_ALU_AND = 4'b0100,
    CRS_ALU_ORA = 4'b0101,
    CRS_ALU_EOR = 4'b0110,
    CRS_ALU_MOV = 4'b0111,
    CRS_ALU_ASL = 4'b1000,
    CRS_ALU_LSR = 4'b1001,
    CRS_ALU_ROL = 4'b1010,
    CRS_ALU_ROR = 4'b1011
  } crs_alu_t;

  typedef enum logic [2:0] {
    CRS_EA_IX = 3'b000,
    CRS_EA_IX1 = 3'b001,
    CRS_EA_IX2 = 3'b010,
    CRS_EA_SP1 = 3'b011,
    CRS_EA_SP2 = 3'b100
  } crs_ea_t;

  typedef enum logic [2:0] {
    CRS_DST_ACC = 3'b000,
    CRS_DST_IDX_HI = 3'b001,
    CRS_DST_IDX_LO = 3'b010,
    CRS_DST_FLAGS = 3'b011,
    CRS_DST_PC_HI = 3'b100,
    CRS_DST_PC_LO = 3'b101
  } crs_dst_t;

  typedef enum logic [1:0] {
    CRS_BR_GT = 2'b00,
    CRS_BR_GE = 2'b01,
    CRS_BR_LE = 2'b10,
    CRS_BR_LT = 2'b11
  } crs_br_t;

endpackage : crs_pkg

// *** rtl/crs_core.sv ***
/*
  Programmer-visible CPU register set: accumulator, index pair, stack
  pointer, program counter and condition flags, with flag generation,
  effective address forming, the reset-vector, interrupt-entry and
  return sequences, and a classic Wishbone slave for register access.
  Assumes the instruction sequencer drives the one-cycle command inputs on
  the same clock, only while busy_o is low, and that the memory returns
  read data in the same cycle that mem_rd_o is high.
*/
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module crs_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // ALU and register loads from the sequencer
  input wire logic alu_go_i,
  input wire crs_pkg::crs_alu_t alu_op_i,
  input wire logic [7:0] alu_operand_i,
  input wire logic acc_load_i,
  input wire logic [7:0] acc_data_i,
  input wire logic index_hi_load_i,
  input wire logic index_lo_load_i,
  input wire logic [7:0] index_data_i,
  // Stack and program flow
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic pull_i,
  input wire crs_pkg::crs_dst_t pull_dst_i,
  input wire logic reset_stack_instr_i,
  input wire logic fetch_i,
  input wire logic pc_load_i,
  input wire logic [15:0] pc_target_i,
  input wire logic instr_done_i,
  input wire logic software_interrupt_instr_i,
  input wire logic return_from_interrupt_instr_i,
  input wire logic clear_mask_instr_i,
  // Interrupt sources
  input wire logic [7:0] irq_req_i,
  input wire logic break_i,
  // Address forming and branch test
  input wire logic ea_go_i,
  input wire crs_pkg::crs_ea_t ea_mode_i,
  input wire logic [15:0] ea_offset_i,
  input wire crs_pkg::crs_br_t br_cond_i,
  // Memory port
  output logic [15:0] mem_addr_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  // Register views
  output logic [7:0] accumulator_o,
  output logic [15:0] index_pair_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] program_counter_o,
  output logic [7:0] condition_flags_o,
  output logic [15:0] eff_addr_o,
  output logic br_taken_o,
  output logic busy_o
);

  crs_pkg::crs_state_t state_reg;
  logic [2:0] step_reg;
  logic [15:0] vec_reg;
  crs_pkg::crs_dst_t rd_dst_reg;
  logic brk_pend_reg;

  // Next-value signals of the sequencer
  crs_pkg::crs_state_t state_next;
  logic [2:0] step_next;
  logic [15:0] vec_next;
  logic rd_next;
  logic wr_next;
  logic [15:0] addr_next;
  logic [7:0] wdata_next;
  crs_pkg::crs_dst_t dst_next;
  logic sp_dec;
  logic sp_inc;
  logic set_mask;
  logic take_brk;

  logic [7:0] alu_res;
  logic [7:0] flags_alu;
  logic wb_req;
  logic wb_wr;

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr = wb_req && we_i;

  // Highest priority is the lowest request bit
  function automatic logic [15:0] irq_vector(input logic [7:0] req);
    logic [15:0] v;
    v = crs_pkg::CRS_VEC_IRQ_TOP;
    for (int k = crs_pkg::CRS_IRQ_W - 1; k >= 0; k--) begin
      if (req[k]) begin
        v = crs_pkg::CRS_VEC_IRQ_TOP - {11'h000, 4'(k), 1'b0};
      end
    end
    return v;
  endfunction : irq_vector

  function automatic logic [7:0] fix_flags(input logic [7:0] f);
    return f | crs_pkg::CRS_FLAGS_ONES;
  endfunction : fix_flags

  // Sequencer: vector fetch, stacking and unstacking
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    vec_next = vec_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    addr_next = mem_addr_o;
    wdata_next = mem_wdata_o;
    dst_next = rd_dst_reg;
    sp_dec = 1'b0;
    sp_inc = 1'b0;
    set_mask = 1'b0;
    take_brk = 1'b0;
    case (state_reg)
      crs_pkg::CRS_ST_IDLE: begin
        if (instr_done_i && (brk_pend_reg || break_i || software_interrupt_instr_i)) begin
          take_brk = 1'b1;
          vec_next = crs_pkg::CRS_VEC_SWI;
          state_next = crs_pkg::CRS_ST_INTR;
          step_next = 3'h0;
        end else if (instr_done_i && !condition_flags_o[crs_pkg::CRS_BIT_I] && (|irq_req_i)) begin
          vec_next = irq_vector(irq_req_i);
          state_next = crs_pkg::CRS_ST_INTR;
          step_next = 3'h0;
        end else if (return_from_interrupt_instr_i) begin
          state_next = crs_pkg::CRS_ST_RTI;
          step_next = 3'h0;
        end else if (push_i) begin
          wr_next = 1'b1;
          addr_next = stack_pointer_o;
          wdata_next = push_data_i;
          sp_dec = 1'b1;
        end else if (pull_i) begin
          rd_next = 1'b1;
          addr_next = stack_pointer_o + 16'h0001;
          dst_next = pull_dst_i;
          sp_inc = 1'b1;
        end
      end
      crs_pkg::CRS_ST_RVEC: begin
        step_next = step_reg + 3'h1;
        if (step_reg == 3'h0) begin
          rd_next = 1'b1;
          addr_next = crs_pkg::CRS_VEC_RESET;
          dst_next = crs_pkg::CRS_DST_PC_HI;
        end else if (step_reg == 3'h1) begin
          rd_next = 1'b1;
          addr_next = crs_pkg::CRS_VEC_RESET + 16'h0001;
          dst_next = crs_pkg::CRS_DST_PC_LO;
        end else begin
          state_next = crs_pkg::CRS_ST_IDLE;
        end
      end
      crs_pkg::CRS_ST_INTR: begin
        step_next = step_reg + 3'h1;
        if (step_reg <= crs_pkg::CRS_INT_STACK_LAST) begin
          wr_next = 1'b1;
          addr_next = stack_pointer_o;
          sp_dec = 1'b1;
          // Upper index byte is left to explicit push and pull
          case (step_reg)
            3'h0: wdata_next = program_counter_o[7:0];
            3'h1: wdata_next = program_counter_o[15:8];
            3'h2: wdata_next = index_pair_o[7:0];
            3'h3: wdata_next = accumulator_o;
            default: wdata_next = condition_flags_o;
          endcase
        end else if (step_reg == crs_pkg::CRS_INT_VEC_HI_STEP) begin
          set_mask = 1'b1;
          rd_next = 1'b1;
          addr_next = vec_reg;
          dst_next = crs_pkg::CRS_DST_PC_HI;
        end else if (step_reg == crs_pkg::CRS_INT_VEC_LO_STEP) begin
          rd_next = 1'b1;
          addr_next = vec_reg + 16'h0001;
          dst_next = crs_pkg::CRS_DST_PC_LO;
        end else begin
          state_next = crs_pkg::CRS_ST_IDLE;
        end
      end
      crs_pkg::CRS_ST_RTI: begin
        step_next = step_reg + 3'h1;
        if (step_reg < crs_pkg::CRS_RTI_DONE_STEP) begin
          rd_next = 1'b1;
          addr_next = stack_pointer_o + 16'h0001;
          sp_inc = 1'b1;
          case (step_reg)
            3'h0: dst_next = crs_pkg::CRS_DST_FLAGS;
            3'h1: dst_next = crs_pkg::CRS_DST_ACC;
            3'h2: dst_next = crs_pkg::CRS_DST_IDX_LO;
            3'h3: dst_next = crs_pkg::CRS_DST_PC_HI;
            default: dst_next = crs_pkg::CRS_DST_PC_LO;
          endcase
        end else begin
          state_next = crs_pkg::CRS_ST_IDLE;
        end
      end
      default: begin
        state_next = crs_pkg::CRS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= crs_pkg::CRS_ST_RVEC;
      step_reg <= 3'h0;
      vec_reg <= crs_pkg::CRS_VEC_RESET;
      busy_o <= 1'b1;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mem_wdata_o <= 8'h00;
      rd_dst_reg <= crs_pkg::CRS_DST_ACC;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      vec_reg <= vec_next;
      busy_o <= (state_next != crs_pkg::CRS_ST_IDLE);
      mem_rd_o <= rd_next;
      mem_wr_o <= wr_next;
      mem_addr_o <= addr_next;
      mem_wdata_o <= wdata_next;
      rd_dst_reg <= dst_next;
    end
  end

  // Break request held until the next instruction boundary; a new break wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_pend_reg <= 1'b0;
    end else if (break_i) begin
      brk_pend_reg <= 1'b1;
    end else if (take_brk) begin
      brk_pend_reg <= 1'b0;
    end
  end

  // Result and flag generation
  always_comb begin
    logic [8:0] sum;
    logic a7;
    logic b7;
    logic cin;
    sum = 9'h000;
    a7 = accumulator_o[7];
    b7 = alu_operand_i[7];
    cin = condition_flags_o[crs_pkg::CRS_BIT_C];
    alu_res = accumulator_o;
    flags_alu = condition_flags_o;
    case (alu_op_i)
      crs_pkg::CRS_ALU_ADD, crs_pkg::CRS_ALU_ADC: begin
        sum = {1'b0, accumulator_o} + {1'b0, alu_operand_i}
            + {8'h00, (alu_op_i == crs_pkg::CRS_ALU_ADC) && cin};
        alu_res = sum[7:0];
        flags_alu[crs_pkg::CRS_BIT_C] = sum[8];
        flags_alu[crs_pkg::CRS_BIT_H] = accumulator_o[4] ^ alu_operand_i[4] ^ sum[4];
        flags_alu[crs_pkg::CRS_BIT_V] = (a7 & b7 & ~sum[7]) | (~a7 & ~b7 & sum[7]);
      end
      crs_pkg::CRS_ALU_SUB, crs_pkg::CRS_ALU_SBC: begin
        sum = {1'b0, accumulator_o} - {1'b0, alu_operand_i}
            - {8'h00, (alu_op_i == crs_pkg::CRS_ALU_SBC) && cin};
        alu_res = sum[7:0];
        flags_alu[crs_pkg::CRS_BIT_C] = sum[8];
        flags_alu[crs_pkg::CRS_BIT_V] = (a7 & ~b7 & ~sum[7]) | (~a7 & b7 & sum[7]);
      end
      crs_pkg::CRS_ALU_AND, crs_pkg::CRS_ALU_ORA, crs_pkg::CRS_ALU_EOR, crs_pkg::CRS_ALU_MOV: begin
        case (alu_op_i)
          crs_pkg::CRS_ALU_AND: alu_res = accumulator_o & alu_operand_i;
          crs_pkg::CRS_ALU_ORA: alu_res = accumulator_o | alu_operand_i;
          crs_pkg::CRS_ALU_EOR: alu_res = accumulator_o ^ alu_operand_i;
          default: alu_res = alu_operand_i;
        endcase
        flags_alu[crs_pkg::CRS_BIT_V] = 1'b0;
      end
      crs_pkg::CRS_ALU_ASL, crs_pkg::CRS_ALU_LSR, crs_pkg::CRS_ALU_ROL, crs_pkg::CRS_ALU_ROR: begin
        case (alu_op_i)
          crs_pkg::CRS_ALU_ASL: alu_res = {accumulator_o[6:0], 1'b0};
          crs_pkg::CRS_ALU_LSR: alu_res = {1'b0, accumulator_o[7:1]};
          crs_pkg::CRS_ALU_ROL: alu_res = {accumulator_o[6:0], cin};
          default: alu_res = {cin, accumulator_o[7:1]};
        endcase
        flags_alu[crs_pkg::CRS_BIT_C] = (alu_op_i == crs_pkg::CRS_ALU_ASL || alu_op_i == crs_pkg::CRS_ALU_ROL)
            ? accumulator_o[7] : accumulator_o[0];
        flags_alu[crs_pkg::CRS_BIT_V] = alu_res[7] ^ flags_alu[crs_pkg::CRS_BIT_C];
      end
      default: begin
        alu_res = accumulator_o;
      end
    endcase
    flags_alu[crs_pkg::CRS_BIT_N] = alu_res[7];
    flags_alu[crs_pkg::CRS_BIT_Z] = (alu_res == 8'h00);
  end

  // Accumulator; sequencer loads override a same-cycle bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accumulator_o <= crs_pkg::CRS_ACC_RESET;
    end else if (mem_rd_o && rd_dst_reg == crs_pkg::CRS_DST_ACC) begin
      accumulator_o <= mem_rdata_i;
    end else if (alu_go_i) begin
      accumulator_o <= alu_res;
    end else if (acc_load_i) begin
      accumulator_o <= acc_data_i;
    end else if (wb_wr && adr_i == crs_pkg::CRS_OFS_ACC && sel_i[0]) begin
      accumulator_o <= dat_i[7:0];
    end
  end

  // Index pair, each byte written on its own
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      index_pair_o <= crs_pkg::CRS_INDEX_RESET;
    end else begin
      if (mem_rd_o && rd_dst_reg == crs_pkg::CRS_DST_IDX_HI) begin
        index_pair_o[15:8] <= mem_rdata_i;
      end else if (index_hi_load_i) begin
        index_pair_o[15:8] <= index_data_i;
      end else if (wb_wr && adr_i == crs_pkg::CRS_OFS_INDEX && sel_i[1]) begin
        index_pair_o[15:8] <= dat_i[15:8];
      end
      if (mem_rd_o && rd_dst_reg == crs_pkg::CRS_DST_IDX_LO) begin
        index_pair_o[7:0] <= mem_rdata_i;
      end else if (index_lo_load_i) begin
        index_pair_o[7:0] <= index_data_i;
      end else if (wb_wr && adr_i == crs_pkg::CRS_OFS_INDEX && sel_i[0]) begin
        index_pair_o[7:0] <= dat_i[7:0];
      end
    end
  end

  // Stack pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stack_pointer_o <= crs_pkg::CRS_SP_RESET;
    end else if (sp_dec) begin
      stack_pointer_o <= stack_pointer_o - 16'h0001;
    end else if (sp_inc) begin
      stack_pointer_o <= stack_pointer_o + 16'h0001;
    end else if (reset_stack_instr_i) begin
      stack_pointer_o[7:0] <= crs_pkg::CRS_SP_LOW_RESET;
    end else if (wb_wr && adr_i == crs_pkg::CRS_OFS_SP) begin
      if (sel_i[0]) begin
        stack_pointer_o[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        stack_pointer_o[15:8] <= dat_i[15:8];
      end
    end
  end

  // Program counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_counter_o <= crs_pkg::CRS_PC_RESET;
    end else if (mem_rd_o && rd_dst_reg == crs_pkg::CRS_DST_PC_HI) begin
      program_counter_o[15:8] <= mem_rdata_i;
    end else if (mem_rd_o && rd_dst_reg == crs_pkg::CRS_DST_PC_LO) begin
      program_counter_o[7:0] <= mem_rdata_i;
    end else if (pc_load_i) begin
      program_counter_o <= pc_target_i;
    end else if (fetch_i) begin
      program_counter_o <= program_counter_o + 16'h0001;
    end else if (wb_wr && adr_i == crs_pkg::CRS_OFS_PC) begin
      if (sel_i[0]) begin
        program_counter_o[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        program_counter_o[15:8] <= dat_i[15:8];
      end
    end
  end

  // Condition flags; a bus write may set the mask but never clear it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      condition_flags_o <= crs_pkg::CRS_FLAGS_RESET;
    end else if (set_mask) begin
      condition_flags_o[crs_pkg::CRS_BIT_I] <= 1'b1;
    end else if (mem_rd_o && rd_dst_reg == crs_pkg::CRS_DST_FLAGS) begin
      condition_flags_o <= fix_flags(mem_rdata_i);
    end else if (clear_mask_instr_i) begin
      condition_flags_o[crs_pkg::CRS_BIT_I] <= 1'b0;
    end else if (alu_go_i) begin
      condition_flags_o <= fix_flags(flags_alu);
    end else if (wb_wr && adr_i == crs_pkg::CRS_OFS_FLAGS && sel_i[0]) begin
      condition_flags_o <= fix_flags(dat_i[7:0]) | (condition_flags_o & 8'h08);
    end
  end

  // Operand address from index or stack pointer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eff_addr_o <= 16'h0000;
    end else if (ea_go_i) begin
      case (ea_mode_i)
        crs_pkg::CRS_EA_IX: eff_addr_o <= index_pair_o;
        crs_pkg::CRS_EA_IX1: eff_addr_o <= index_pair_o + {8'h00, ea_offset_i[7:0]};
        crs_pkg::CRS_EA_IX2: eff_addr_o <= index_pair_o + ea_offset_i;
        crs_pkg::CRS_EA_SP1: eff_addr_o <= stack_pointer_o + {8'h00, ea_offset_i[7:0]};
        crs_pkg::CRS_EA_SP2: eff_addr_o <= stack_pointer_o + ea_offset_i;
        default: eff_addr_o <= index_pair_o;
      endcase
    end
  end

  // Signed branch test on the flags as they stand
  logic nv;
  assign nv = condition_flags_o[crs_pkg::CRS_BIT_N] ^ condition_flags_o[crs_pkg::CRS_BIT_V];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      br_taken_o <= 1'b0;
    end else begin
      case (br_cond_i)
        crs_pkg::CRS_BR_GT: br_taken_o <= !(condition_flags_o[crs_pkg::CRS_BIT_Z] || nv);
        crs_pkg::CRS_BR_GE: br_taken_o <= !nv;
        crs_pkg::CRS_BR_LE: br_taken_o <= condition_flags_o[crs_pkg::CRS_BIT_Z] || nv;
        default: br_taken_o <= nv;
      endcase
    end
  end

  // Wishbone: answer one cycle after the request, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          crs_pkg::CRS_OFS_ACC: dat_o <= {24'h000000, accumulator_o};
          crs_pkg::CRS_OFS_INDEX: dat_o <= {16'h0000, index_pair_o};
          crs_pkg::CRS_OFS_SP: dat_o <= {16'h0000, stack_pointer_o};
          crs_pkg::CRS_OFS_PC: dat_o <= {16'h0000, program_counter_o};
          crs_pkg::CRS_OFS_FLAGS: dat_o <= {24'h000000, condition_flags_o};
          crs_pkg::CRS_OFS_STATUS: dat_o <= {26'h0000000, brk_pend_reg, busy_o, 1'b0, state_reg};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule : crs_core

// *** tb/crs_core_checker.sv ***
/* Assertion checker for the CPU register set core.
   Assumes the sequencer issues commands only while busy_o is low. */
`timescale 1ns/1ps
module crs_core_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic push_i,
  input wire logic pull_i,
  input wire logic reset_stack_instr_i,
  input wire logic fetch_i,
  input wire logic pc_load_i,
  input wire logic clear_mask_instr_i,
  input wire logic instr_done_i,
  input wire logic return_from_interrupt_instr_i,
  input wire logic busy_o,
  input wire logic mem_rd_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [15:0] program_counter_o,
  input wire logic [7:0] condition_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Plain command slot: no sequence or boundary competing
  logic quiet;
  assign quiet = !busy_o && !instr_done_i && !return_from_interrupt_instr_i;
  sequence s_vec_hi; mem_rd_o && mem_addr_o == 16'hFFFE; endsequence
  sequence s_vec_lo; mem_rd_o && mem_addr_o == 16'hFFFF; endsequence
  property p_ones; condition_flags_o[6:5] == 2'h3; endproperty
  a_ones: assert property (p_ones) else $error("flag bits 6 and 5 not one");
  property p_push; quiet && push_i |=> stack_pointer_o == $past(stack_pointer_o) - 16'h0001; endproperty
  a_push: assert property (p_push) else $error("push did not decrement");
  property p_pull; quiet && pull_i && !push_i |=> stack_pointer_o == $past(stack_pointer_o) + 16'h0001; endproperty
  a_pull: assert property (p_pull) else $error("pull did not increment");
  property p_rsp;
    quiet && reset_stack_instr_i && !push_i && !pull_i |=> stack_pointer_o[7:0] == 8'hFF &&
      ((stack_pointer_o ^ $past(stack_pointer_o)) & 16'hFF00) == 16'h0000;
  endproperty
  a_rsp: assert property (p_rsp) else $error("stack reset wrong");
  property p_fetch; quiet && fetch_i && !pc_load_i |=> program_counter_o == $past(program_counter_o) + 16'h0001; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not step");
  property p_vec; $fell(rst_i) |=> s_vec_hi ##1 s_vec_lo; endproperty
  a_vec: assert property (p_vec) else $error("vector fetch order wrong");
  // Must look inside reset itself
  property p_mask_rst; disable iff (1'b0) rst_i |=> condition_flags_o[3]; endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask not set by reset");
  property p_cli; quiet && clear_mask_instr_i |=> !condition_flags_o[3]; endproperty
  a_cli: assert property (p_cli) else $error("mask not cleared");
  property p_mask_hold;
    !busy_o && condition_flags_o[3] && !clear_mask_instr_i && !return_from_interrupt_instr_i |=> condition_flags_o[3];
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask cleared without command");
endmodule : crs_core_checker
bind crs_core crs_core_checker chk_u (.*);

// *** tb/crs_core_tb.sv ***
/* Self-checking bench for crs_core: reset vector, ALU flags, stack, bus.
   Memory is a fixed function of the address, answered in the same cycle. */
`timescale 1ns/1ps
module crs_core_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, alu_go_i = 1'b0, acc_load_i = 1'b0;
  logic index_hi_load_i = 1'b0, index_lo_load_i = 1'b0, push_i = 1'b0, pull_i = 1'b0, reset_stack_instr_i = 1'b0;
  logic fetch_i = 1'b0, pc_load_i = 1'b0, instr_done_i = 1'b0, software_interrupt_instr_i = 1'b0, break_i = 1'b0;
  logic return_from_interrupt_instr_i = 1'b0, clear_mask_instr_i = 1'b0, ea_go_i = 1'b0, ack_o, mem_rd_o, mem_wr_o;
  logic [7:0] adr_i = 8'h00, alu_operand_i = 8'h00, acc_data_i = 8'h00, index_data_i = 8'h00, push_data_i = 8'h00;
  logic [7:0] irq_req_i = 8'h00, mem_wdata_o, mem_rdata_i, accumulator_o, condition_flags_o, m_acc, m_flags;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [15:0] pc_target_i = 16'h0, ea_offset_i = 16'h0, mem_addr_o, index_pair_o, stack_pointer_o;
  logic [15:0] program_counter_o, eff_addr_o;
  logic br_taken_o, busy_o;
  crs_pkg::crs_alu_t alu_op_i = crs_pkg::CRS_ALU_ADD;
  crs_pkg::crs_dst_t pull_dst_i = crs_pkg::CRS_DST_ACC;
  crs_pkg::crs_ea_t ea_mode_i = crs_pkg::CRS_EA_IX;
  crs_pkg::crs_br_t br_cond_i = crs_pkg::CRS_BR_GT;
  crs_pkg::crs_alu_t ops [4] = '{crs_pkg::CRS_ALU_ADD, crs_pkg::CRS_ALU_ADC, crs_pkg::CRS_ALU_SUB, crs_pkg::CRS_ALU_AND};
  int fail_count = 0, checks = 0, cycles = 0, seed = 87803;
  assign mem_rdata_i = mem_addr_o[15:8] + mem_addr_o[7:0];
  crs_core dut_u (.*);
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ends every command pulse except acc_load_i and software_interrupt_instr_i, then settles to mid-cycle
  task fin;
    @(posedge clk_i);
    {alu_go_i, push_i, pull_i, reset_stack_instr_i, fetch_i, pc_load_i, ea_go_i, instr_done_i} <= 8'h0;
    {clear_mask_instr_i, index_hi_load_i, index_lo_load_i, break_i, return_from_interrupt_instr_i} <= 5'h0;
    @(negedge clk_i);
  endtask : fin
  task seq(input logic [10:0] c, input logic [31:0] e);
    @(posedge clk_i);
    {instr_done_i, return_from_interrupt_instr_i, break_i, irq_req_i} <= c;
    fin();
    repeat (9) @(negedge clk_i);
    chk({program_counter_o, stack_pointer_o[7:0], condition_flags_o}, e);
  endtask : seq
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'h0;
    @(negedge clk_i);
  endtask : wb
  task alu(input crs_pkg::crs_alu_t op, input logic [7:0] b);
    logic [8:0] r;
    logic cin;
    cin = (op == crs_pkg::CRS_ALU_ADC) & m_flags[0];
    if (op == crs_pkg::CRS_ALU_SUB) begin
      r = {1'b0, m_acc} - {1'b0, b};
      m_flags[7] = (m_acc[7] != b[7]) && (r[7] != m_acc[7]);
    end else if (op == crs_pkg::CRS_ALU_AND) begin
      r = {m_flags[0], m_acc & b};
      m_flags[7] = 1'b0;
    end else begin
      r = {1'b0, m_acc} + {1'b0, b} + cin;
      m_flags[7] = (m_acc[7] == b[7]) && (r[7] != m_acc[7]);
      m_flags[4] = ({1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + cin) > 5'hF;
    end
    {m_flags[0], m_acc} = r;
    m_flags[2] = r[7];
    m_flags[1] = r[7:0] == 8'h00;
    @(posedge clk_i);
    {alu_go_i, alu_operand_i} <= {1'b1, b};
    alu_op_i <= op;
    fin();
    chk(accumulator_o, m_acc);
    chk(condition_flags_o, m_flags);
  endtask : alu
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    while (busy_o !== 1'b0) @(posedge clk_i);
    @(negedge clk_i);
    chk(program_counter_o, 16'hFDFE);
    chk(stack_pointer_o, 16'h00FF);
    chk(condition_flags_o, 8'h68);
    m_acc = 8'h00;
    m_flags = 8'h68;
    repeat (40) alu(ops[$unsigned($random(seed)) % 4], 8'($random(seed)));
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      {push_i, push_data_i} <= {1'b1, 8'($random(seed))};
      fin();
      chk(stack_pointer_o, 16'h00FE - 16'(k));
    end
    @(posedge clk_i);
    pull_i <= 1'b1;
    fin();
    repeat (2) @(negedge clk_i);
    chk(stack_pointer_o, 16'h00FE);
    chk(accumulator_o, 8'hFE);
    wb(1'b1, crs_pkg::CRS_OFS_SP, 32'h1234);
    @(posedge clk_i);
    reset_stack_instr_i <= 1'b1;
    fin();
    wb(1'b0, crs_pkg::CRS_OFS_SP, 32'h0);
    chk(q, 32'h12FF);
    @(posedge clk_i);
    {ea_go_i, ea_offset_i} <= {1'b1, 16'h0010};
    ea_mode_i <= crs_pkg::CRS_EA_SP1;
    fin();
    chk(eff_addr_o, 16'h130F);
    wb(1'b1, crs_pkg::CRS_OFS_INDEX, 32'hABCD);
    @(posedge clk_i);
    ea_go_i <= 1'b1;
    ea_mode_i <= crs_pkg::CRS_EA_IX;
    fin();
    chk(eff_addr_o, 16'hABCD);
    @(posedge clk_i);
    {index_lo_load_i, index_data_i} <= {1'b1, 8'h5A};
    fin();
    chk(index_pair_o, 16'hAB5A);
    wb(1'b1, crs_pkg::CRS_OFS_FLAGS, 32'h0);
    chk(condition_flags_o, 8'h68);
    @(posedge clk_i);
    clear_mask_instr_i <= 1'b1;
    fin();
    chk(condition_flags_o, 8'h60);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    @(posedge clk_i);
    {pc_load_i, pc_target_i} <= {1'b1, 16'h1FFF};
    fin();
    @(posedge clk_i);
    fetch_i <= 1'b1;
    fin();
    chk(program_counter_o, 16'h2000);
    seq(11'h406, 32'hF7F8FA68);
    seq(11'h200, 32'h1011FF6D);
    seq(11'h500, 32'hFBFCFA6D);
    give_verdict();
  end
endmodule : crs_core_tb
